// *** design/srt_pkg.sv ***
package srt_pkg;
  `include "srt_rtc_map.svh"

  typedef enum logic [2:0] {
    SRT_IDLE = 3'b000,
    SRT_ADDR = 3'b001,
    SRT_PTR = 3'b010,
    SRT_WR = 3'b011,
    SRT_RD = 3'b100
  } srt_state_t;

  // Next BCD value, wrapping from last back to first
  function automatic logic [7:0] srt_bcd_next(input logic [7:0] v, input logic [7:0] last,
                                               input logic [7:0] first);
    if (v >= last)
      return first;
    else if (v[3:0] >= `SRT_BCD_NINE)
      return {v[7:4] + 4'h1, 4'h0};
    else
      return {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Year 00 counts as leap: the century rolls over through it
  function automatic logic srt_is_leap(input logic [7:0] y);
    if (y[4])
      return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else
      return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  function automatic logic [7:0] srt_month_last(input logic [7:0] m, input logic leap);
    case (m)
      8'h02: return leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
      default: return 8'h31;
    endcase
  endfunction

  // Bits that hold data in each clock register; the rest read as zero
  function automatic logic [7:0] srt_field_mask(input logic [2:0] idx);
    case (idx)
      `SRT_REG_MIN: return 8'h7F;
      `SRT_REG_DAY: return 8'h07;
      `SRT_REG_DATE: return 8'h3F;
      `SRT_REG_MONTH: return 8'h1F;
      default: return 8'hFF;
    endcase
  endfunction
endpackage

// *** design/srt_ram.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "srt_rtc_map.svh"
module srt_ram
  import srt_pkg::*;
(
  input wire logic mclk,
  srt_ram_if.mem bus
);
  logic [7:0] mem_r [0:`SRT_RAM_DEPTH-1];
  logic [7:0] rdata_r;

  always_ff @(posedge mclk)
  begin
    if (bus.we && (bus.addr < 6'(`SRT_RAM_DEPTH)))
      mem_r[bus.addr] <= bus.wdata;
  end

  always_ff @(posedge mclk)
  begin
    if (bus.addr < 6'(`SRT_RAM_DEPTH))
      rdata_r <= mem_r[bus.addr];
    else
      rdata_r <= `SRT_BCD_ZERO;
  end

  assign bus.rdata = rdata_r;
endmodule
`default_nettype wire

// *** design/srt_ram_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface srt_ram_if;
  logic we;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport host (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// *** design/srt_rtc_map.svh ***
`ifndef SRT_RTC_MAP_SVH
`define SRT_RTC_MAP_SVH

// Bus address and register layout
`define SRT_SLAVE_ADDR 7'h68
`define SRT_PTR_W 6
`define SRT_PTR_RESET 6'h00
`define SRT_REG_SEC 3'h0
`define SRT_REG_MIN 3'h1
`define SRT_REG_HOUR 3'h2
`define SRT_REG_DAY 3'h3
`define SRT_REG_DATE 3'h4
`define SRT_REG_MONTH 3'h5
`define SRT_REG_YEAR 3'h6
`define SRT_REG_CTRL 3'h7
`define SRT_CLOCK_REGS 8
`define SRT_RAM_BASE 6'h08
`define SRT_RAM_DEPTH 56

// Field positions
`define SRT_HALT_BIT 7
`define SRT_CEB_BIT 7
`define SRT_CB_BIT 6
`define SRT_OUT_BIT 7
`define SRT_FT_BIT 6

// BCD limits and reset values
`define SRT_BCD_ZERO 8'h00
`define SRT_BCD_ONE 8'h01
`define SRT_BCD_NINE 4'h9
`define SRT_SEC_LAST 8'h59
`define SRT_HOUR_LAST 8'h23
`define SRT_DAY_LAST 8'h07
`define SRT_MONTH_LAST 8'h12
`define SRT_YEAR_LAST 8'h99
`define SRT_CTRL_RESET 8'h80

// Serial bit counting
`define SRT_BIT_LAST 4'h7
`define SRT_BIT_ACK 4'h8
// Loaded at START so the scl fall that follows it wraps to bit zero
`define SRT_BIT_START 4'hF

// Crystal divider
`define SRT_XTAL_HZ 32768
`define SRT_XTAL_W 15
`define SRT_FT_DIV_BIT 5

`endif

// *** design/srt_rtc_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "srt_rtc_map.svh"
// Overview of operation
// - Device is only a bus slave; addressed by START then slave address D0h.
// - Locations run seconds to control, then RAM at locations 8 to 63.
// - Pointer advances by one after every data byte written or read.
// - First seven locations are clock/calendar, values held in BCD.
// - Supply loss aborts any access and clears the address pointer.
// - Below switchover all bus inputs are ignored; accepted again on recovery.
// - Location 0 halt bit plus BCD seconds; location 1 BCD minutes, D7 ignored.
// - Location 2 holds century enable, century flag and BCD hours 00-23.
// - With century enable set, flag inverts every hundred years; else never changes.
// - Locations 3-6 hold weekday, date, month, year in BCD, high bits of 3-5 ignored.
// - Location 7 control: output level, frequency test, calibration sign, magnitude; sign and magnitude are stored but not applied to timekeeping.
// - Timekeeping paced from the 32.768 kHz crystal oscillator.
// - Calendar handles leap years when passing end of February.
// - Data falling while clock high is a START.
// - Data rising while clock high is a STOP, ending the transfer.
// - Data changes only while clock low; one clock pulse per bit.
// - Transfers open with START, close with STOP, no byte limit.
// - Bytes move MSB first, receiver acknowledges on the ninth clock.
// - When receiving, device pulls data low through the acknowledge clock.
// - Master withholds acknowledge on last read byte; device releases data line.
module srt_rtc_top
  import srt_pkg::*;
#(
  parameter int XTAL_TICKS = `SRT_XTAL_HZ
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic vcc_ok,
  input wire logic crystal_input,
  output logic crystal_output,
  output logic test_or_level_pin_out,
  output logic test_or_level_pin_oe_n
);
  srt_ram_if ram_bus ();
  logic scl_m_r, scl_s_r, scl_d_r;
  logic sda_m_r, sda_s_r, sda_d_r;
  logic vok_m_r, vok_s_r;
  logic scl_rise, scl_fall, start_seen, stop_seen;

  srt_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic sda_oe_n_r;
  logic sda_out_r;
  logic [`SRT_PTR_W-1:0] ptr_r;
  logic wr_pulse_r;
  logic [7:0] wr_data_r;
  logic byte_done, ack_done, rd_load;
  logic [7:0] rd_byte;

  logic [7:0] tk_r [0:`SRT_CLOCK_REGS-1];
  logic tk_we;
  logic sec_tick, test_wave, xtal_level;
  logic [7:0] sec_n, min_n, hour_n, day_n, date_n, month_n, year_n;
  logic c_sec, c_min, c_hour, c_date, c_month, c_year;
  logic [7:0] date_last;
  logic xo_r, pin_out_r, pin_oe_n_r;

  // Pin synchronisers; only second stages and later are looked at
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
      vok_m_r <= 1'b0;
      vok_s_r <= 1'b0;
    end
    else
    begin
      scl_m_r <= scl;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
      vok_m_r <= vcc_ok;
      vok_s_r <= vok_m_r;
    end
  end

  assign scl_rise = scl_s_r && !scl_d_r;
  assign scl_fall = !scl_s_r && scl_d_r;
  assign start_seen = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
  assign stop_seen = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;

  assign byte_done = scl_fall && (bit_cnt_r == `SRT_BIT_LAST);
  assign ack_done = scl_fall && (bit_cnt_r == `SRT_BIT_ACK);
  assign rd_load = ack_done && ((state_r == SRT_RD) || ((state_r == SRT_ADDR) && shift_r[0]));

  // Read source: clock registers below the RAM base, RAM above it
  always_comb
  begin
    if (ptr_r < `SRT_RAM_BASE)
      rd_byte = tk_r[ptr_r[2:0]] & srt_field_mask(ptr_r[2:0]);
    else
      rd_byte = ram_bus.rdata;
  end

  // Serial protocol engine
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= SRT_IDLE;
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      sda_oe_n_r <= 1'b1;
    end
    else if (!vok_s_r)
    begin
      // Low supply: drop the access and listen to nothing
      state_r <= SRT_IDLE;
      bit_cnt_r <= 4'h0;
      sda_oe_n_r <= 1'b1;
    end
    else if (start_seen)
    begin
      state_r <= SRT_ADDR;
      bit_cnt_r <= `SRT_BIT_START;
      sda_oe_n_r <= 1'b1;
    end
    else if (stop_seen)
    begin
      state_r <= SRT_IDLE;
      bit_cnt_r <= 4'h0;
      sda_oe_n_r <= 1'b1;
    end
    else if (state_r != SRT_IDLE)
    begin
      if (scl_rise && (bit_cnt_r != `SRT_BIT_ACK))
        shift_r <= {shift_r[6:0], sda_s_r};
      if (scl_rise && (bit_cnt_r == `SRT_BIT_ACK) && (state_r == SRT_RD) && sda_s_r)
        state_r <= SRT_IDLE;
      if (scl_fall)
      begin
        if (bit_cnt_r == `SRT_BIT_LAST)
        begin
          bit_cnt_r <= `SRT_BIT_ACK;
          unique case (state_r)
            SRT_ADDR:
            begin
              if (shift_r[7:1] == `SRT_SLAVE_ADDR)
                sda_oe_n_r <= 1'b0;
              else
                state_r <= SRT_IDLE;
            end
            SRT_PTR, SRT_WR: sda_oe_n_r <= 1'b0;
            SRT_RD: sda_oe_n_r <= 1'b1;
            default: state_r <= SRT_IDLE;
          endcase
        end
        else if (bit_cnt_r == `SRT_BIT_ACK)
        begin
          bit_cnt_r <= 4'h0;
          sda_oe_n_r <= 1'b1;
          if (rd_load)
          begin
            tx_r <= rd_byte;
            sda_oe_n_r <= rd_byte[7];
          end
          if (state_r == SRT_ADDR)
            state_r <= shift_r[0] ? SRT_RD : SRT_PTR;
          else if (state_r == SRT_PTR)
            state_r <= SRT_WR;
        end
        else
        begin
          bit_cnt_r <= bit_cnt_r + 4'h1;
          if (state_r == SRT_RD)
          begin
            tx_r <= {tx_r[6:0], 1'b0};
            sda_oe_n_r <= tx_r[6];
          end
        end
      end
    end
  end

  // Address pointer and write strobe
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      ptr_r <= `SRT_PTR_RESET;
      wr_pulse_r <= 1'b0;
      wr_data_r <= 8'h00;
    end
    else if (!vok_s_r)
    begin
      ptr_r <= `SRT_PTR_RESET;
      wr_pulse_r <= 1'b0;
    end
    else
    begin
      wr_pulse_r <= byte_done && (state_r == SRT_WR) && !start_seen && !stop_seen;
      if (byte_done)
        wr_data_r <= shift_r;
      if (byte_done && (state_r == SRT_PTR))
        ptr_r <= shift_r[`SRT_PTR_W-1:0];
      else if (wr_pulse_r || rd_load)
        ptr_r <= ptr_r + 1'b1;
    end
  end

  assign tk_we = wr_pulse_r && (ptr_r < `SRT_RAM_BASE);
  assign ram_bus.we = wr_pulse_r && (ptr_r >= `SRT_RAM_BASE);
  assign ram_bus.addr = ptr_r - `SRT_RAM_BASE;
  assign ram_bus.wdata = wr_data_r;

  srt_ram u_ram (
    .mclk(mclk),
    .bus(ram_bus)
  );

  // Writing the seconds restarts the second so a set time is exact
  srt_xtal_div #(
    .XTAL_TICKS(XTAL_TICKS)
  ) u_div (
    .mclk(mclk),
    .rstn(rstn),
    .xtal(crystal_input),
    .clr(tk_we && (ptr_r[2:0] == `SRT_REG_SEC)),
    .sec_tick(sec_tick),
    .test_wave(test_wave),
    .xtal_level(xtal_level)
  );

  // BCD carry chain
  always_comb
  begin
    sec_n = srt_bcd_next({1'b0, tk_r[0][6:0]}, `SRT_SEC_LAST, `SRT_BCD_ZERO);
    c_sec = {1'b0, tk_r[0][6:0]} >= `SRT_SEC_LAST;
    min_n = srt_bcd_next({1'b0, tk_r[1][6:0]}, `SRT_SEC_LAST, `SRT_BCD_ZERO);
    c_min = {1'b0, tk_r[1][6:0]} >= `SRT_SEC_LAST;
    hour_n = srt_bcd_next({2'b00, tk_r[2][5:0]}, `SRT_HOUR_LAST, `SRT_BCD_ZERO);
    c_hour = {2'b00, tk_r[2][5:0]} >= `SRT_HOUR_LAST;
    day_n = srt_bcd_next({5'h00, tk_r[3][2:0]}, `SRT_DAY_LAST, `SRT_BCD_ONE);
    date_last = srt_month_last({3'h0, tk_r[5][4:0]}, srt_is_leap(tk_r[6]));
    date_n = srt_bcd_next({2'b00, tk_r[4][5:0]}, date_last, `SRT_BCD_ONE);
    c_date = {2'b00, tk_r[4][5:0]} >= date_last;
    month_n = srt_bcd_next({3'h0, tk_r[5][4:0]}, `SRT_MONTH_LAST, `SRT_BCD_ONE);
    c_month = {3'h0, tk_r[5][4:0]} >= `SRT_MONTH_LAST;
    year_n = srt_bcd_next(tk_r[6], `SRT_YEAR_LAST, `SRT_BCD_ZERO);
    c_year = tk_r[6] >= `SRT_YEAR_LAST;
  end

  // Clock/calendar registers
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      tk_r[0] <= `SRT_BCD_ZERO;
      tk_r[1] <= `SRT_BCD_ZERO;
      tk_r[2] <= `SRT_BCD_ZERO;
      tk_r[3] <= `SRT_BCD_ONE;
      tk_r[4] <= `SRT_BCD_ONE;
      tk_r[5] <= `SRT_BCD_ONE;
      tk_r[6] <= `SRT_BCD_ZERO;
      tk_r[7] <= `SRT_CTRL_RESET;
    end
    else if (tk_we)
      tk_r[ptr_r[2:0]] <= wr_data_r & srt_field_mask(ptr_r[2:0]);
    else if (sec_tick && !tk_r[0][`SRT_HALT_BIT])
    begin
      tk_r[0][6:0] <= sec_n[6:0];
      if (c_sec)
      begin
        tk_r[1][6:0] <= min_n[6:0];
        if (c_min)
        begin
          tk_r[2][5:0] <= hour_n[5:0];
          if (c_hour)
          begin
            tk_r[3][2:0] <= day_n[2:0];
            tk_r[4][5:0] <= date_n[5:0];
            if (c_date)
            begin
              tk_r[5][4:0] <= month_n[4:0];
              if (c_month)
              begin
                tk_r[6] <= year_n;
                if (c_year && tk_r[2][`SRT_CEB_BIT])
                  tk_r[2][`SRT_CB_BIT] <= !tk_r[2][`SRT_CB_BIT];
              end
            end
          end
        end
      end
    end
  end

  // Open-drain sda and level pins: enable low pulls the line low, high releases it; crystal output driven inverted
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      sda_out_r <= 1'b0;
      xo_r <= 1'b1;
      pin_out_r <= 1'b0;
      pin_oe_n_r <= 1'b1;
    end
    else
    begin
      sda_out_r <= 1'b0;
      xo_r <= !xtal_level;
      pin_out_r <= 1'b0;
      if (tk_r[7][`SRT_FT_BIT])
        pin_oe_n_r <= test_wave;
      else
        pin_oe_n_r <= tk_r[7][`SRT_OUT_BIT];
    end
  end

  assign sda_out = sda_out_r;
  assign sda_oe_n = sda_oe_n_r;
  assign crystal_output = xo_r;
  assign test_or_level_pin_out = pin_out_r;
  assign test_or_level_pin_oe_n = pin_oe_n_r;
endmodule
`default_nettype wire

// *** design/srt_xtal_div.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "srt_rtc_map.svh"
module srt_xtal_div
  import srt_pkg::*;
#(
  parameter int XTAL_TICKS = `SRT_XTAL_HZ
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic xtal,
  input wire logic clr,
  output logic sec_tick,
  output logic test_wave,
  output logic xtal_level
);
  logic xtal_m_r, xtal_s_r, xtal_d_r;
  logic [`SRT_XTAL_W-1:0] cnt_r;
  logic tick_r;

  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      xtal_m_r <= 1'b0;
      xtal_s_r <= 1'b0;
      xtal_d_r <= 1'b0;
    end
    else
    begin
      xtal_m_r <= xtal;
      xtal_s_r <= xtal_m_r;
      xtal_d_r <= xtal_s_r;
    end
  end

  // Divide crystal edges down to one pulse a second
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      tick_r <= 1'b0;
      if (clr)
        cnt_r <= '0;
      else if (xtal_s_r && !xtal_d_r)
      begin
        if (cnt_r == `SRT_XTAL_W'(XTAL_TICKS - 1))
        begin
          cnt_r <= '0;
          tick_r <= 1'b1;
        end
        else
          cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign sec_tick = tick_r;
  assign test_wave = cnt_r[`SRT_FT_DIV_BIT];
  assign xtal_level = xtal_s_r;
endmodule
`default_nettype wire

// *** tb/serial_rtc_with_ram_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module serial_rtc_with_ram_tb_top;
  import srt_pkg::*;
  localparam logic [7:0] RST_V [8] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h80};
  localparam logic [7:0] TW [4][7] = '{'{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h04},
    '{8'h59, 8'h59, 8'hA3, 8'h03, 8'h31, 8'h12, 8'h99},
    '{8'h59, 8'h59, 8'h63, 8'h03, 8'h31, 8'h12, 8'h99},
    '{8'h59, 8'h59, 8'h23, 8'h02, 8'h28, 8'h02, 8'h03}};
  localparam logic [7:0] TE [4][7] = '{'{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h04},
    '{8'h00, 8'h00, 8'hC0, 8'h04, 8'h01, 8'h01, 8'h00},
    '{8'h00, 8'h00, 8'h40, 8'h04, 8'h01, 8'h01, 8'h00},
    '{8'h00, 8'h00, 8'h00, 8'h03, 8'h01, 8'h03, 8'h03}};
  localparam logic [7:0] BAD [3] = '{8'hA0, 8'hD2, 8'h50};
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic vcc_ok = 1'b1;
  logic xtal = 1'b0;
  logic scl, sda_drv, sda, sda_out, sda_oe_n, xout, pin_out, pin_oe_n, k;
  logic [7:0] wb [64];
  logic [7:0] rb [64];
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  int p, n;
  // Pull-up: the wire is low only when someone pulls it
  assign sda = sda_drv & (sda_oe_n | sda_out);
  initial
  begin
    forever #4 mclk = ~mclk;
  end
  srt_i2c_master m (.mclk(mclk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  srt_rtc_top #(.XTAL_TICKS(4)) dut (.mclk(mclk), .rstn(rstn), .scl(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .vcc_ok(vcc_ok), .crystal_input(xtal),
    .crystal_output(xout), .test_or_level_pin_out(pin_out), .test_or_level_pin_oe_n(pin_oe_n));
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      errors++;
      conclude();
    end
  end
  function automatic logic [7:0] fmask(input int i);
    case (i)
      1: return 8'h7F;
      3: return 8'h07;
      4: return 8'h3F;
      5: return 8'h1F;
      default: return 8'hFF;
    endcase
  endfunction
  task automatic addr(input logic [7:0] a);
    m.start();
    m.wbyte(8'hD0, k);
    `CHK(k, 1'b0)
    m.wbyte(a, k);
    `CHK(k, 1'b0)
  endtask
  task automatic wr(input logic [7:0] a, input int cnt);
    addr(a);
    for (int i = 0; i < cnt; i++)
    begin
      m.wbyte(wb[i], k);
      `CHK(k, 1'b0)
    end
    m.stop();
  endtask
  // Pointer 8'hFF reads on from wherever the pointer stands
  task automatic rd(input logic [7:0] a, input int cnt);
    if (!a[7])
      addr(a);
    m.start();
    m.wbyte(8'hD1, k);
    `CHK(k, 1'b0)
    for (int i = 0; i < cnt; i++)
      m.rbyte(i == cnt - 1, rb[i]);
    m.stop();
  endtask
  task automatic xt(input int cnt);
    repeat (cnt)
    begin
      repeat (10) @(negedge mclk);
      xtal = 1'b1;
      repeat (10) @(negedge mclk);
      xtal = 1'b0;
    end
  endtask
  initial
  begin
    void'($urandom(32'hEC10));
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    repeat (6) @(negedge mclk);
    rd(8'h00, 8);
    for (int i = 0; i < 8; i++)
      `CHK(rb[i], RST_V[i])
    $display("test reset done");
    for (int i = 0; i < 6; i++)
      wb[i] = 8'hFF;
    wr(8'h01, 6);
    rd(8'h01, 6);
    for (int i = 0; i < 6; i++)
      `CHK(rb[i], fmask(i + 1))
    wb[0] = 8'h00;
    wr(8'h07, 1);
    `CHK(pin_oe_n, 1'b0)
    // Test wave stays in its low phase with a four-tick second
    wb[0] = 8'hC0;
    wr(8'h07, 1);
    `CHK(pin_oe_n, 1'b0)
    wb[0] = 8'h80;
    wr(8'h07, 1);
    `CHK(pin_oe_n, 1'b1)
    $display("test fields done");
    repeat (3)
    begin
      p = $urandom_range(8, 28);
      n = $urandom_range(2, 30);
      for (int i = 0; i < n; i++)
        wb[i] = 8'($urandom);
      wr(8'(p), n);
      rd(8'(p), n);
      for (int i = 0; i < n; i++)
        `CHK(rb[i], wb[i])
    end
    wb[0] = 8'($urandom);
    wb[1] = 8'h00;
    wr(8'h3F, 2);
    rd(8'h3F, 2);
    `CHK(rb[0], wb[0])
    `CHK(rb[1], 8'h00)
    $display("test ram done");
    for (int c = 0; c < 4; c++)
    begin
      for (int i = 0; i < 7; i++)
        wb[i] = TW[c][i];
      wr(8'h00, 7);
      xt(3);
      rd(8'h00, 1);
      `CHK(rb[0], 8'h59)
      xt(1);
      rd(8'h00, 7);
      for (int i = 0; i < 7; i++)
        `CHK(rb[i], TE[c][i])
    end
    wb[0] = 8'hC5;
    wr(8'h00, 1);
    xt(8);
    rd(8'h00, 1);
    `CHK(rb[0], 8'hC5)
    wb[0] = 8'h45;
    wr(8'h00, 1);
    xt(4);
    rd(8'h00, 1);
    `CHK(rb[0], 8'h46)
    $display("test time done");
    foreach (BAD[j])
    begin
      m.start();
      m.wbyte(BAD[j], k);
      `CHK(k, 1'b1)
      m.wbyte(8'h00, k);
      `CHK(k, 1'b1)
      m.stop();
    end
    $display("test address done");
    wb[0] = 8'h3C;
    wr(8'h10, 1);
    addr(8'h10);
    vcc_ok = 1'b0;
    repeat (10) @(negedge mclk);
    m.wbyte(8'h5A, k);
    `CHK(k, 1'b1)
    m.stop();
    vcc_ok = 1'b1;
    repeat (10) @(negedge mclk);
    rd(8'hFF, 1);
    `CHK(rb[0], 8'h46)
    rd(8'h10, 1);
    `CHK(rb[0], 8'h3C)
    $display("test supply done");
    conclude();
  end
endmodule
`default_nettype wire

// *** tb/srt_i2c_master.sv ***
`timescale 1ns/100ps
`default_nettype none
module srt_i2c_master
(
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  initial
  begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Data moves only while scl low, one pulse a bit
  task automatic bit_io(input logic v, output logic r);
    scl = 1'b0;
    w(2);
    sda_drv = v;
    w(3);
    scl = 1'b1;
    w(3);
    r = sda;
    w(2);
  endtask
  task automatic cond(input logic a);
    scl = 1'b0;
    w(2);
    sda_drv = a;
    w(3);
    scl = 1'b1;
    w(5);
    sda_drv = ~a;
    w(5);
  endtask
  task automatic start();
    cond(1'b1);
  endtask
  task automatic stop();
    cond(1'b0);
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, ack);
  endtask
  // Last byte left unacknowledged so the device lets go
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, b[i]);
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// *** tb/srt_rtc_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "srt_rtc_map.svh"
module srt_rtc_monitor
  import srt_pkg::*;
#(
  parameter int XTAL_TICKS = `SRT_XTAL_HZ
)
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic vcc_ok,
  input wire logic crystal_input,
  input wire logic crystal_output,
  input wire logic test_or_level_pin_out,
  input wire logic test_or_level_pin_oe_n
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  sequence s_start;
    scl && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl && $rose(sda_in);
  endsequence
  sequence s_drive;
    vcc_ok && $fell(sda_oe_n);
  endsequence
  AST_SDA_LOW_ONLY: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  AST_PIN_LOW_ONLY: assert property (test_or_level_pin_out == 1'b0)
    else $error("level pin driven high");
  AST_VCC_QUIET: assert property (!vcc_ok [*4] |-> sda_oe_n && test_or_level_pin_oe_n)
    else $error("pins driven while supply low");
  AST_CHANGE_LOW: assert property (vcc_ok && $past(vcc_ok, 4) && $changed(sda_oe_n) |-> !scl)
    else $error("sda changed while scl high");
  AST_DRIVE_TO_RISE: assert property (s_drive |-> (!sda_oe_n throughout ##[1:8] scl))
    else $error("sda pull dropped before scl high");
  AST_STOP_FREE: assert property (s_stop |-> sda_oe_n [*5])
    else $error("sda driven after stop");
  AST_START_FREE: assert property (s_start |-> sda_oe_n [*3])
    else $error("sda driven at start");
  AST_XTAL_FOLLOW: assert property ($rose(crystal_input) |-> ##[1:4] !crystal_output)
    else $error("crystal output not inverted");
endmodule
bind srt_rtc_top srt_rtc_monitor #(.XTAL_TICKS(XTAL_TICKS)) u_mon (.mclk(mclk), .rstn(rstn),
  .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .vcc_ok(vcc_ok),
  .crystal_input(crystal_input), .crystal_output(crystal_output),
  .test_or_level_pin_out(test_or_level_pin_out), .test_or_level_pin_oe_n(test_or_level_pin_oe_n));
`default_nettype wire
